// ---- core/tws_pkg.sv ----
package tws_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_MODE   = 16'hff80;
    localparam logic [15:0] ADDR_CLKSEL = 16'hff81;
    localparam logic [15:0] ADDR_SHIFT  = 16'hff82;
    localparam logic [7:0]  MODE_RESET  = 8'h00;
    localparam logic [7:0]  ZERO_BYTE   = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EN_BIT   = 7;
    localparam int MODE_BIT = 6;
    localparam int DIR_BIT  = 4;
    localparam int BUSY_BIT = 0;
    localparam int CKP_BIT  = 1;
    localparam int DAP_BIT  = 0;

    // ------------------------------------------------------------
    // transfer shape
    // ------------------------------------------------------------
    localparam int          DATA_W     = 8;
    localparam int          FIFO_DEPTH = 8;
    localparam logic [2:0]  FIRST_IDX  = 3'h0;
    localparam logic [2:0]  LAST_IDX   = 3'h7;
    localparam logic [2:0]  IDX_STEP   = 3'h1;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_XFER = 1'b1
    } tws_state_t;
endpackage

// ---- core/tws_top.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// receive byte buffer
// ------------------------------------------------------------
module tws_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         clr,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
    logic         push, pop;

    // pointer arithmetic and flags
    always_comb begin
        in_ready  = (wp_q - rp_q) != (AW+1)'(D);
        out_valid = wp_q != rp_q;
        out_data  = mem_q[rp_q[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wp_d      = clr ? '0 : wp_q + (AW+1)'(push);
        rp_d      = clr ? '0 : rp_q + (AW+1)'(pop);
    end

    // storage and pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule // tws_fifo

// ------------------------------------------------------------
// three-wire serial mode control
// ------------------------------------------------------------
// Function
// - reset clears mode register to zero
// - enable bit seven; clear resets asynchronously
// - disable clears busy flag and shift data
// - mode bit six: receive or transmit/receive
// - receive-only mode holds data out low
// - receive-only: shift register read starts reception
// - bit four selects msb or lsb first
// - bit zero is read-only busy flag
// - disabled interface releases pins to port
// - clock and data phase bits; only their XOR picks the sampling edge, so two types
module tws_top (
    // system
    input  wire logic       CLK,
    input  wire logic       RST,
    // register port
    input  wire logic [15:0] ADDR,
    input  wire logic       WR,
    input  wire logic       RD,
    input  wire logic [7:0] WDATA,
    output logic [7:0]      RDATA,
    // serial link
    input  wire logic       SCK,
    input  wire logic       SI,
    output logic            SO,
    output logic            SO_OE,
    // event
    output logic            TRANSFER_DONE
);
    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] mirror_idx(input logic [2:0] i);
        mirror_idx = tws_pkg::LAST_IDX - i;
    endfunction
    function automatic logic pick_bit(input logic [7:0] w, input logic [2:0] i,
                                      input logic lsb);
        pick_bit = lsb ? w[i] : w[mirror_idx(i)];
    endfunction
    function automatic logic [7:0] rev8(input logic [7:0] w);
        for (int k = 0; k < tws_pkg::DATA_W; k++) begin
            rev8[k] = w[tws_pkg::DATA_W-1-k];
        end
    endfunction

    // ------------------------------------------------------------
    // control domain state
    // ------------------------------------------------------------
    logic              en_q, en_d, mode_q, mode_d, dir_q, dir_d, ckp_q, ckp_d, dap_q, dap_d;
    tws_pkg::tws_state_t st_q, st_d;
    logic [7:0]        tx_q, tx_d, rdata_q, rdata_d;
    logic              so_q, so_d, oe_q, oe_d, done_q, done_d;
    logic              tg_s1, tg_s2, tg_s3;
    logic [2:0]        gc_s1, gc_s2, bit_idx;
    logic              wr_mode, wr_clk, wr_sh, rd_mode, rd_clk, rd_sh, done_evt, start;
    logic              f_in_ready, f_out_valid, f_clr;
    logic [7:0]        f_out_data, rx_byte;
    logic              lk_rst;
    logic              sclk;
    logic [2:0]        cnt_q, cnt_d, gray_q, gray_d;
    logic [7:0]        sh_q, sh_d, hold_q, hold_d;
    logic              tgl_q, tgl_d;

    // register port decode
    always_comb begin
        wr_mode  = WR && (ADDR == tws_pkg::ADDR_MODE);
        wr_clk   = WR && (ADDR == tws_pkg::ADDR_CLKSEL);
        wr_sh    = WR && (ADDR == tws_pkg::ADDR_SHIFT);
        rd_mode  = RD && (ADDR == tws_pkg::ADDR_MODE);
        rd_clk   = RD && (ADDR == tws_pkg::ADDR_CLKSEL);
        rd_sh    = RD && (ADDR == tws_pkg::ADDR_SHIFT);
        done_evt = tg_s2 ^ tg_s3;
        bit_idx  = {gc_s2[2], gc_s2[2] ^ gc_s2[1], gc_s2[2] ^ gc_s2[1] ^ gc_s2[0]};
        rx_byte  = dir_q ? rev8(hold_q) : hold_q;
        f_clr    = !en_q;
    end

    // control next state
    always_comb begin
        en_d    = en_q;
        mode_d  = mode_q;
        dir_d   = dir_q;
        ckp_d   = ckp_q;
        dap_d   = dap_q;
        st_d    = st_q;
        tx_d    = tx_q;
        done_d  = 1'b0;
        rdata_d = rdata_q;
        start   = 1'b0;
        // enable and mode, order; bits 5 and 3 to 0 are not stored
        if (wr_mode) begin
            en_d   = WDATA[tws_pkg::EN_BIT];
            mode_d = WDATA[tws_pkg::MODE_BIT];
            dir_d  = WDATA[tws_pkg::DIR_BIT];
        end
        if (wr_clk) begin
            ckp_d = WDATA[tws_pkg::CKP_BIT];
            dap_d = WDATA[tws_pkg::DAP_BIT];
        end
        // write starts duplex transfer, read starts reception
        if (en_q && st_q == tws_pkg::ST_IDLE && f_in_ready) begin
            if (wr_sh && mode_q) begin
                start = 1'b1;
                tx_d  = WDATA;
            end else if (rd_sh && !mode_q) begin
                start = 1'b1;
            end
        end
        // busy from start to eighth bit, then done pulse
        unique case (st_q)
            tws_pkg::ST_IDLE: begin
                if (start) begin
                    st_d = tws_pkg::ST_XFER;
                end
            end
            tws_pkg::ST_XFER: begin
                if (done_evt) begin
                    st_d   = tws_pkg::ST_IDLE;
                    done_d = 1'b1;
                end
            end
        endcase
        // disable drops busy and shift data
        if (!en_q) begin
            st_d   = tws_pkg::ST_IDLE;
            tx_d   = tws_pkg::ZERO_BYTE;
            done_d = 1'b0;
        end
        // busy flag reads back in bit zero
        if (rd_mode) begin
            rdata_d = tws_pkg::ZERO_BYTE;
            rdata_d[tws_pkg::EN_BIT]   = en_q;
            rdata_d[tws_pkg::MODE_BIT] = mode_q;
            rdata_d[tws_pkg::DIR_BIT]  = dir_q;
            rdata_d[tws_pkg::BUSY_BIT] = (st_q == tws_pkg::ST_XFER);
        end else if (rd_clk) begin
            rdata_d = tws_pkg::ZERO_BYTE;
            rdata_d[tws_pkg::CKP_BIT] = ckp_q;
            rdata_d[tws_pkg::DAP_BIT] = dap_q;
        end else if (rd_sh) begin
            rdata_d = f_out_valid ? f_out_data : tws_pkg::ZERO_BYTE;
        end
        so_d = en_q && mode_q && pick_bit(tx_q, bit_idx, dir_q);
        oe_d = en_q;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            en_q    <= 1'b0;
            mode_q  <= 1'b0;
            dir_q   <= 1'b0;
            ckp_q   <= 1'b0;
            dap_q   <= 1'b0;
            st_q    <= tws_pkg::ST_IDLE;
            tx_q    <= tws_pkg::MODE_RESET;
            rdata_q <= tws_pkg::MODE_RESET;
            so_q    <= 1'b0;
            oe_q    <= 1'b0;
            done_q  <= 1'b0;
            tg_s1   <= 1'b0;
            tg_s2   <= 1'b0;
            tg_s3   <= 1'b0;
            gc_s1   <= tws_pkg::FIRST_IDX;
            gc_s2   <= tws_pkg::FIRST_IDX;
        end else begin
            en_q    <= en_d;
            mode_q  <= mode_d;
            dir_q   <= dir_d;
            ckp_q   <= ckp_d;
            dap_q   <= dap_d;
            st_q    <= st_d;
            tx_q    <= tx_d;
            rdata_q <= rdata_d;
            so_q    <= so_d;
            oe_q    <= oe_d;
            done_q  <= done_d;
            tg_s1   <= tgl_q;
            tg_s2   <= tg_s1 && en_q; // disable resets the toggle: keep that edge out
            tg_s3   <= tg_s2 && en_q;
            gc_s1   <= gray_q;
            gc_s2   <= gc_s1;
        end
    end

    // outputs straight from flops
    always_comb begin
        RDATA         = rdata_q;
        SO            = so_q;
        SO_OE         = oe_q;
        TRANSFER_DONE = done_q;
    end

    // receive buffer, full stalls new starts
    tws_fifo #(.W(tws_pkg::DATA_W), .D(tws_pkg::FIFO_DEPTH)) tws_fifo_inst (
        .clk       (CLK),
        .rst       (RST),
        .clr       (f_clr),
        .in_valid  (done_evt && st_q == tws_pkg::ST_XFER),
        .in_ready  (f_in_ready),
        .in_data   (rx_byte),
        .out_valid (f_out_valid),
        .out_ready (rd_sh),
        .out_data  (f_out_data)
    );

    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    // sample always on rising edge of the phase-adjusted clock
    always_comb begin
        sclk   = SCK ^ ckp_q ^ dap_q;
        lk_rst = !en_q;
        cnt_d  = cnt_q + tws_pkg::IDX_STEP;
        gray_d = cnt_d ^ (cnt_d >> 1);
        sh_d   = {sh_q[6:0], SI};
        hold_d = hold_q;
        tgl_d  = tgl_q;
        // eighth bit hands the byte over
        if (cnt_q == tws_pkg::LAST_IDX) begin
            hold_d = sh_d;
            tgl_d  = !tgl_q;
        end
    end

    always_ff @(posedge sclk or posedge lk_rst) begin
        if (lk_rst) begin
            cnt_q  <= tws_pkg::FIRST_IDX;
            gray_q <= tws_pkg::FIRST_IDX;
            sh_q   <= tws_pkg::ZERO_BYTE;
            hold_q <= tws_pkg::ZERO_BYTE;
            tgl_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            gray_q <= gray_d;
            sh_q   <= sh_d;
            hold_q <= hold_d;
            tgl_q  <= tgl_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_reset_zero:
    assert property ($fell(RST) |-> !en_q && !mode_q && !dir_q && st_q == tws_pkg::ST_IDLE)
        else $error("mode state not zero after reset");
    chk_disable_pin:
    assert property (wr_mode && !WDATA[tws_pkg::EN_BIT] |=> ##1 !SO_OE && !SO)
        else $error("pin still driven after disable");
    chk_disable_clear:
    assert property (wr_mode && !WDATA[tws_pkg::EN_BIT] |=> ##1 st_q == tws_pkg::ST_IDLE
                     && !f_out_valid && tx_q == tws_pkg::ZERO_BYTE)
        else $error("disable left busy or data");
    chk_rx_low:
    assert property (!mode_q |=> !SO)
        else $error("data out not low in receive mode");
    chk_rx_start:
    assert property (rd_sh && en_q && !mode_q && st_q == tws_pkg::ST_IDLE && f_in_ready
                     |=> st_q == tws_pkg::ST_XFER)
        else $error("read did not start reception");
    chk_order_read:
    assert property (rd_mode |=> RDATA[tws_pkg::DIR_BIT] == $past(dir_q)
                     && RDATA[tws_pkg::BUSY_BIT] == $past(st_q == tws_pkg::ST_XFER))
        else $error("mode readback wrong");
    chk_busy_ro:
    assert property (wr_mode && WDATA[tws_pkg::BUSY_BIT] && st_q == tws_pkg::ST_IDLE
                     |=> st_q == tws_pkg::ST_IDLE)
        else $error("busy flag writable");
    chk_phase_sel:
    assert property (wr_clk |=> ckp_q == $past(WDATA[tws_pkg::CKP_BIT])
                     && dap_q == $past(WDATA[tws_pkg::DAP_BIT]))
        else $error("phase select not stored");
    chk_done_pulse:
    assert property (done_evt && st_q == tws_pkg::ST_XFER && en_q
                     |=> TRANSFER_DONE && st_q == tws_pkg::ST_IDLE ##1 !TRANSFER_DONE)
        else $error("end of transfer not signalled");
    chk_tx_start:
    assert property (wr_sh && en_q && mode_q && st_q == tws_pkg::ST_IDLE && f_in_ready
                     |=> st_q == tws_pkg::ST_XFER && tx_q == $past(WDATA))
        else $error("write did not start transfer");
endmodule // tws_top

// ---- bench/tws_peer.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// external serial master on the three-wire link
// ------------------------------------------------------------
module tws_peer (
    // link pins
    output logic      sck,
    output logic      si,
    input  wire logic so
);
    logic idle_lvl;

    // quiet link at time zero
    initial begin
        sck = 1'b0;
        si = 1'b0;
        idle_lvl = 1'b0;
    end

    task automatic idle(input logic ckp, input logic dap);
        idle_lvl = ckp ^ dap;
        sck = ckp ^ dap;
    endtask

    task automatic frame(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            si = tx[i];
            #16;
            rx = {rx[6:0], so}; // bit seen before sampling edge
            sck = ~idle_lvl;
            #16;
            sck = idle_lvl;
        end
        si = ~si; // inverted line shows no stale bit
    endtask
endmodule // tws_peer

// ---- bench/tws_top_test.sv ----
`timescale 1ns/1ps

module tws_top_test;
    logic        CLK, RST, WR, RD, SCK, SI, SO, SO_OE, TRANSFER_DONE;
    logic [15:0] ADDR;
    logic [7:0]  WDATA, RDATA, v, seen;
    int          mismatches, tests_run, done_cnt;

    tws_top tws_top_inst (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WR(WR), .RD(RD),
        .WDATA(WDATA), .RDATA(RDATA), .SCK(SCK), .SI(SI), .SO(SO), .SO_OE(SO_OE),
        .TRANSFER_DONE(TRANSFER_DONE));
    tws_peer tws_peer_inst (.sck(SCK), .si(SI), .so(SO));

    // system clock
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    // count completion pulses
    always @(posedge CLK) begin
        if (TRANSFER_DONE === 1'b1) done_cnt <= done_cnt + 1;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] rev(input logic [7:0] b);
        for (int i = 0; i < 8; i++) rev[i] = b[7-i];
    endfunction

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(posedge CLK);
        #1 d = RDATA;
    endtask

    task automatic cfg(input logic ckp, input logic dap, input logic [7:0] mode);
        wr(tws_pkg::ADDR_MODE, 8'h00);
        wr(tws_pkg::ADDR_CLKSEL, {6'h00, ckp, dap});
        tws_peer_inst.idle(ckp, dap);
        wr(tws_pkg::ADDR_MODE, mode);
    endtask

    task automatic xfer(input logic [7:0] tx, input logic [7:0] rxd, input logic dir);
        int n;
        // completion counted afresh for each start
        n = done_cnt + 1;
        wr(tws_pkg::ADDR_SHIFT, tx);
        rd(tws_pkg::ADDR_MODE, v);
        check(v, {3'h6, dir, 4'h1});
        tws_peer_inst.frame(rxd, 8, seen);
        for (int i = 0; i < 50 && done_cnt < n; i++) @(posedge CLK);
        check(8'(done_cnt), 8'(n));
        check(seen, dir ? rev(tx) : tx);
        rd(tws_pkg::ADDR_MODE, v);
        check(v, {3'h6, dir, 4'h0});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(tws_pkg::ADDR_MODE, v);
        check(v, 8'h00);
        check({6'h00, SO, SO_OE}, 8'h00);
        // bit five and bits three to zero read back zero
        wr(tws_pkg::ADDR_MODE, 8'h9f);
        rd(tws_pkg::ADDR_MODE, v);
        check(v, 8'h90);
        check({7'h00, SO_OE}, 8'h01);
        rd(16'hff90, v);
        check(v, 8'h90);
    endtask

    task automatic t_phases();
        for (int c = 0; c < 8; c++) begin
            cfg(c[2], c[1], {3'h6, c[0], 4'h0});
            rd(tws_pkg::ADDR_CLKSEL, v);
            check(v, {6'h00, c[2], c[1]});
            xfer(8'h96 + 8'(c), 8'h3b + 8'(c), c[0]);
            rd(tws_pkg::ADDR_SHIFT, v);
            check(v, c[0] ? rev(8'h3b + 8'(c)) : 8'h3b + 8'(c));
        end
    endtask

    task automatic t_fill();
        cfg(1'b0, 1'b0, 8'hc0);
        for (int i = 0; i < 8; i++) xfer(8'h10 + 8'(i), 8'h40 + 8'(i), 1'b0);
        wr(tws_pkg::ADDR_SHIFT, 8'hee);
        rd(tws_pkg::ADDR_MODE, v);
        check(v, 8'hc0);
        for (int i = 0; i < 8; i++) begin
            rd(tws_pkg::ADDR_SHIFT, v);
            check(v, 8'h40 + 8'(i));
        end
    endtask

    task automatic t_rxonly_abort();
        cfg(1'b0, 1'b0, 8'h80);
        rd(tws_pkg::ADDR_SHIFT, v);
        check(v, 8'h00);
        check({7'h00, SO}, 8'h00);
        rd(tws_pkg::ADDR_MODE, v);
        check(v, 8'h81);
        tws_peer_inst.frame(8'h3c, 8, seen);
        check(seen, 8'h00);
        repeat (10) @(posedge CLK);
        rd(tws_pkg::ADDR_SHIFT, v);
        check(v, 8'h3c);
        tws_peer_inst.frame(8'hf0, 4, seen);
        wr(tws_pkg::ADDR_MODE, 8'h00);
        rd(tws_pkg::ADDR_MODE, v);
        check(v, 8'h00);
        check({7'h00, SO_OE}, 8'h00);
        wr(tws_pkg::ADDR_MODE, 8'hc0);
        rd(tws_pkg::ADDR_SHIFT, v);
        check(v, 8'h00);
        xfer(8'h81, 8'h7e, 1'b0);
        rd(tws_pkg::ADDR_SHIFT, v);
        check(v, 8'h7e);
        // duplex byte still loaded, receive-only must mask it
        wr(tws_pkg::ADDR_MODE, 8'h80);
        rd(tws_pkg::ADDR_MODE, v);
        check(v, 8'h80);
        check({7'h00, SO}, 8'h00);
    endtask

    // reset and main sequence
    initial begin
        RST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 16'h0000;
        WDATA = 8'h00;
        done_cnt = 0;
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        t_reset();
        t_phases();
        t_fill();
        t_rxonly_abort();
        conclude();
    end

    // watchdog
    initial begin
        #300000;
        mismatches++;
        conclude();
    end
endmodule // tws_top_test
